// [ieg_map.svh]
`ifndef IEG_MAP_SVH
`define IEG_MAP_SVH

// Word geometry
`define IEG_WORD_W 32
`define IEG_SRC_W 12
`define IEG_RESET_VAL 32'h0000_0000

// Writable-bit masks per layout; zero bits are reserved
`define IEG_MASK_SINGLE 32'h073F_073F
`define IEG_MASK_SINGLE_2SP 32'h07FF_07FF
`define IEG_MASK_DUAL 32'hFFFF_0F3F

// Source index, equal to the processor-side bit position
`define IEG_B_EXT 0
`define IEG_B_S0TX 4
`define IEG_B_S0RX 5
`define IEG_B_S1TX 6
`define IEG_B_S1RX 7
`define IEG_B_T0 8
`define IEG_B_T1 9
`define IEG_B_DONE0 10
`define IEG_B_DONE1 11

// Single-channel DMA field starts here
`define IEG_DMA_OFS 16

// Dual-channel DMA field positions
`define IEG_D0_EXT 16
`define IEG_D0_S0TX 20
`define IEG_D1_S0RX 21
`define IEG_D1_T0 22
`define IEG_D1_T1 23
`define IEG_D0_T0 24
`define IEG_D0_T1 25
`define IEG_D0_XDONE 26
`define IEG_D1_XDONE 27
`define IEG_D1_EXT 28

`endif

// [ieg_pkg.sv]
package ieg_pkg;

  // Register layout selected at build time
  typedef enum {
    IEG_SINGLE_ONE_SERIAL,
    IEG_SINGLE_TWO_SERIAL,
    IEG_DUAL_CHANNEL
  } ieg_layout_type;

  // State of one completion flag
  typedef struct packed {
    logic flag;
  } ieg_flag_state_type;

  // State of the enable block
  typedef struct packed {
    logic [31:0] word;
    logic [3:0] ext_s1;
    logic [3:0] ext_s2;
    logic [11:0] cpu_irq;
    logic [11:0] dma0_trig;
    logic [11:0] dma1_trig;
  } ieg_state_type;

endpackage : ieg_pkg

// [ieg_done_flag.sv]
`timescale 1ns/10ps
`default_nettype none

module ieg_done_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Channel events
  input wire logic count_zero,
  input wire logic tc_irq_ctl,
  input wire logic flag_clear,
  // Sticky completion flag
  output logic flag
);

  ieg_pkg::ieg_flag_state_type st_r;
  ieg_pkg::ieg_flag_state_type st_nxt;

  // Set beats clear so a completion in the clear cycle survives
  always_comb
  begin
    st_nxt = st_r;
    if (flag_clear)
    begin
      st_nxt.flag = 1'b0;
    end
    if (count_zero && tc_irq_ctl)
    begin
      st_nxt.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_FLAG_SET: assert property (count_zero && tc_irq_ctl |=> flag)
    else $error("completion flag not raised");
  AST_FLAG_QUIET: assert property (!flag && !tc_irq_ctl |=> !flag)
    else $error("completion flag raised without control bit");

endmodule : ieg_done_flag

`default_nettype wire

// [ieg_top.sv]
// Behaviour
// - Enable word is one 32-bit register
// - Single layout: processor enables in low bits
// - Single layout: DMA enables in bits 16-26
// - Enable bit one passes its source
// - Enable bit zero blocks its source
// - Reset clears the whole word
// - Reserved bits read zero, ignore writes
// - Enable bits read back last written value
// - Bits 0-3 gate external inputs 0-3
// - Bits 4,5 gate serial 0 transmit, receive
// - Bits 6,7 serial 1 only with two ports
// - Bits 8,9 gate timer 0 and timer 1
// - Single layout: bit 10 gates DMA completion
// - Single DMA field mirrors low field plus 16
// - Dual: bits 10,11 gate channel completions
// - Dual: channel 0 DMA enable positions
// - Dual: channel 1 DMA enable positions
// - Dual: bits 26,27 cross-channel completion triggers
// - Completion flag needs count zero and control
// - Completion reaches processor only when enabled

`include "ieg_map.svh"

`timescale 1ns/10ps
`default_nettype none

module ieg_top #(
  // Build-time layout choice
  parameter ieg_pkg::ieg_layout_type LAYOUT = ieg_pkg::IEG_SINGLE_ONE_SERIAL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register-file write and read port
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  // External interrupt pins, asynchronous
  input wire logic [3:0] ext_irq_pin,
  // On-chip interrupt sources, same clock
  input wire logic serial0_tx_irq,
  input wire logic serial0_rx_irq,
  input wire logic serial1_tx_irq,
  input wire logic serial1_rx_irq,
  input wire logic timer0_irq,
  input wire logic timer1_irq,
  // DMA channel completion events
  input wire logic [1:0] chan_count_zero,
  input wire logic [1:0] terminal_count_irq_ctl,
  input wire logic [1:0] chan_done_clear,
  // Sticky completion flags
  output logic [1:0] chan_done_flag,
  // Gated requests, indexed like the processor-side bits
  output logic [11:0] cpu_irq_out,
  output logic [11:0] dma0_trig_out,
  output logic [11:0] dma1_trig_out
);

  // Layout derived flags
  localparam bit IS_DUAL = (LAYOUT == ieg_pkg::IEG_DUAL_CHANNEL);
  localparam bit TWO_SERIAL = (LAYOUT == ieg_pkg::IEG_SINGLE_TWO_SERIAL);

  // Writable bits of the word for a layout
  function automatic logic [31:0] ieg_mask(input ieg_pkg::ieg_layout_type lay);
    logic [31:0] m;
    m = `IEG_MASK_SINGLE;
    case (lay)
      ieg_pkg::IEG_SINGLE_TWO_SERIAL: m = `IEG_MASK_SINGLE_2SP;
      ieg_pkg::IEG_DUAL_CHANNEL: m = `IEG_MASK_DUAL;
      default: m = `IEG_MASK_SINGLE;
    endcase
    return m;
  endfunction : ieg_mask

  // Per-source enables of one DMA channel in the dual layout;
  // positions follow the bit diagram, not the label text
  function automatic logic [11:0] ieg_dual_en(input logic [31:0] w, input logic chan);
    logic [11:0] e;
    e = 12'h000;
    if (!chan)
    begin
      e[`IEG_B_EXT +: 4] = w[`IEG_D0_EXT +: 4];
      e[`IEG_B_S0TX] = w[`IEG_D0_S0TX];
      e[`IEG_B_T0] = w[`IEG_D0_T0];
      e[`IEG_B_T1] = w[`IEG_D0_T1];
      e[`IEG_B_DONE1] = w[`IEG_D0_XDONE];
    end
    else
    begin
      e[`IEG_B_EXT +: 4] = w[`IEG_D1_EXT +: 4];
      e[`IEG_B_S0RX] = w[`IEG_D1_S0RX];
      e[`IEG_B_T0] = w[`IEG_D1_T0];
      e[`IEG_B_T1] = w[`IEG_D1_T1];
      e[`IEG_B_DONE0] = w[`IEG_D1_XDONE];
    end
    return e;
  endfunction : ieg_dual_en

  // Fixed mask for this build
  localparam logic [31:0] WR_MASK = ieg_mask(LAYOUT);

  // Registered state and its next value
  ieg_pkg::ieg_state_type st_r;
  ieg_pkg::ieg_state_type st_nxt;

  // Flags from the completion logic
  logic [1:0] done_flag;
  // Completion events allowed for this layout
  logic [1:0] count_zero_gated;
  // All sources, indexed like the processor bits
  logic [11:0] src;
  // Per-source enables toward each target
  logic [11:0] cpu_en;
  logic [11:0] dma0_en;
  logic [11:0] dma1_en;

  // Channel 1 does not exist in the single layout
  assign count_zero_gated = {chan_count_zero[1] & IS_DUAL, chan_count_zero[0]};

  // One sticky completion flag per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_done
      ieg_done_flag u_flag (
        .clk(clk),
        .resetn(resetn),
        .count_zero(count_zero_gated[ch]),
        .tc_irq_ctl(terminal_count_irq_ctl[ch]),
        .flag_clear(chan_done_clear[ch]),
        .flag(done_flag[ch])
      );
    end
  endgenerate

  // Assemble the source vector; absent sources read as idle
  always_comb
  begin
    src = 12'h000;
    src[`IEG_B_EXT +: 4] = st_r.ext_s2;
    src[`IEG_B_S0TX] = serial0_tx_irq;
    src[`IEG_B_S0RX] = serial0_rx_irq;
    src[`IEG_B_S1TX] = serial1_tx_irq & TWO_SERIAL;
    src[`IEG_B_S1RX] = serial1_rx_irq & TWO_SERIAL;
    src[`IEG_B_T0] = timer0_irq;
    src[`IEG_B_T1] = timer1_irq;
    src[`IEG_B_DONE0] = done_flag[0];
    src[`IEG_B_DONE1] = done_flag[1] & IS_DUAL;
  end

  // Decode the word into per-target enable vectors
  always_comb
  begin
    cpu_en = st_r.word[11:0];
    if (IS_DUAL)
    begin
      dma0_en = ieg_dual_en(st_r.word, 1'b0);
      dma1_en = ieg_dual_en(st_r.word, 1'b1);
    end
    else
    begin
      // Same source order, shifted up by the DMA offset
      dma0_en = st_r.word[`IEG_DMA_OFS +: 12];
      dma1_en = 12'h000;
    end
  end

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    // Pins pass two flops before anything reads them
    st_nxt.ext_s1 = ext_irq_pin;
    st_nxt.ext_s2 = st_r.ext_s1;
    // Reserved bits never store, so they always read zero
    if (wr_en)
    begin
      st_nxt.word = wr_data & WR_MASK;
    end
    // A one passes the source, a zero blocks it; the gate adds
    // one cycle so that every output comes from a flop
    st_nxt.cpu_irq = src & cpu_en;
    st_nxt.dma0_trig = src & dma0_en;
    st_nxt.dma1_trig = src & dma1_en;
  end

  // State register; reset leaves every source disabled
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign rd_data = st_r.word;
  assign cpu_irq_out = st_r.cpu_irq;
  assign dma0_trig_out = st_r.dma0_trig;
  assign dma1_trig_out = st_r.dma1_trig;
  assign chan_done_flag = done_flag;

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_RESERVED_ZERO: assert property ((rd_data & ~WR_MASK) == 32'h0000_0000)
    else $error("reserved bit reads nonzero");

  AST_WRITE_READBACK: assert property (wr_en |=> rd_data == ($past(wr_data) & WR_MASK))
    else $error("read does not return written value");

  AST_HOLD_VALUE: assert property (!wr_en |=> $stable(rd_data))
    else $error("enable word changed without a write");

  AST_RESET_CLEAR: assert property (!$past(resetn) |-> rd_data == `IEG_RESET_VAL)
    else $error("word not cleared by reset");

  AST_EXT_PASS: assert property (
    (ext_irq_pin[0] && rd_data[0] && !wr_en) [*3] |=> cpu_irq_out[0])
    else $error("external input 0 not passed after sync");

  AST_TIMER_PASS: assert property (
    timer0_irq && rd_data[`IEG_B_T0] |=> cpu_irq_out[`IEG_B_T0])
    else $error("timer 0 request not passed");

  AST_DONE_BLOCK: assert property (
    !rd_data[`IEG_B_DONE0] |=> !cpu_irq_out[`IEG_B_DONE0])
    else $error("completion reached processor while disabled");

  AST_SINGLE_DMA: assert property (
    !IS_DUAL && done_flag[0] && rd_data[26] |=> dma0_trig_out[`IEG_B_DONE0])
    else $error("single-layout DMA completion gate failed");

  AST_DUAL_CROSS: assert property (
    IS_DUAL && done_flag[0] && rd_data[`IEG_D1_XDONE] |=> dma1_trig_out[`IEG_B_DONE0])
    else $error("channel 0 completion did not trigger channel 1");

  AST_BLOCK_ALL: assert property (rd_data == 32'h0000_0000 |=> cpu_irq_out == 12'h000)
    else $error("request passed with all enables clear");

  // Main scenarios
  COV_WRITE: cover property (wr_en ##1 rd_data != 32'h0000_0000);
  COV_CPU_IRQ: cover property (cpu_irq_out != 12'h000);
  COV_DMA_TRIG: cover property (dma0_trig_out != 12'h000);
  COV_DONE: cover property (done_flag[0] ##1 cpu_irq_out[`IEG_B_DONE0]);

endmodule : ieg_top

`default_nettype wire

// [cpu_dma_interrupt_enable_reg_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ieg_map.svh"

module cpu_dma_interrupt_enable_reg_bench;
  // Clock, reset and shared stimulus
  logic clk, resetn, wr_en;
  logic [31:0] wr_data;
  logic [3:0] ext_irq_pin;
  logic s0tx, s0rx, s1tx, s1rx, t0, t1;
  logic [1:0] cnt_zero, tc_ctl, done_clr;
  // Outputs of the three layouts, indexed by layout number
  wire logic [31:0] rd [3];
  wire logic [11:0] cpu [3];
  wire logic [11:0] d0 [3];
  wire logic [11:0] d1 [3];
  wire logic [1:0] flg [3];
  // Verdict counters and hang guard
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  // One instance per layout, all fed the same stimulus
  for (genvar g = 0; g < 3; g++)
  begin : lay
    ieg_top #(.LAYOUT(ieg_pkg::ieg_layout_type'(g))) ieg_top_i (
      .clk(clk), .resetn(resetn), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd[g]),
      .ext_irq_pin(ext_irq_pin), .serial0_tx_irq(s0tx), .serial0_rx_irq(s0rx),
      .serial1_tx_irq(s1tx), .serial1_rx_irq(s1rx), .timer0_irq(t0), .timer1_irq(t1),
      .chan_count_zero(cnt_zero), .terminal_count_irq_ctl(tc_ctl),
      .chan_done_clear(done_clr), .chan_done_flag(flg[g]), .cpu_irq_out(cpu[g]),
      .dma0_trig_out(d0[g]), .dma1_trig_out(d1[g]));
  end

  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // Writable mask of each layout
  function automatic logic [31:0] msk(input int l);
    case (l)
      0: msk = `IEG_MASK_SINGLE;
      1: msk = `IEG_MASK_SINGLE_2SP;
      default: msk = `IEG_MASK_DUAL;
    endcase
  endfunction : msk

  // Expected {dma1, dma0, cpu} gated requests for an already masked word
  function automatic logic [35:0] exp_gate(input int l, input logic [31:0] w,
                                           input logic [11:0] s);
    logic [11:0] src, c, e0, e1;
    src = s;
    // Second serial port only on the two-port variant, second channel only dual
    if (l != 1) src[7:6] = 2'h0;
    if (l != 2) src[11] = 1'h0;
    c = w[11:0] & src;
    if (l == 2)
    begin
      e0 = {w[26], 1'b0, w[25:24], 3'h0, w[20], w[19:16]} & src;
      e1 = {1'b0, w[27], w[23:22], 2'h0, w[21], 1'b0, w[31:28]} & src;
    end
    else
    begin
      e0 = w[27:16] & src;
      e1 = 12'h000;
    end
    exp_gate = {e1, e0, c};
  endfunction : exp_gate

  // Compare and count; four-state safe
  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One register write, strobe held for exactly one edge
  task automatic wr(input logic [31:0] w);
    @(posedge clk);
    #1 wr_en = 1'b1;
    wr_data = w;
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask : wr

  // All level sources together
  task automatic set_src(input logic v);
    ext_irq_pin = {4{v}};
    {s0tx, s0rx, s1tx, s1rx, t0, t1} = {6{v}};
  endtask : set_src

  // Settle past the slowest path (synced pins), then judge every layout
  task automatic chk_gate(input logic [31:0] w, input logic [11:0] s);
    logic [35:0] e;
    repeat (4) @(posedge clk);
    #1;
    for (int l = 0; l < 3; l++)
    begin
      e = exp_gate(l, w & msk(l), s);
      chk("rd_data", w & msk(l), rd[l]);
      chk("cpu_irq_out", e[11:0], cpu[l]);
      chk("dma0_trig_out", e[23:12], d0[l]);
      chk("dma1_trig_out", e[35:24], d1[l]);
    end
  endtask : chk_gate

  // Completion flag: control gates the set, set beats clear, clear works
  task automatic test_flags;
    @(posedge clk);
    #1 cnt_zero = 2'h3;
    @(posedge clk);
    #1 cnt_zero = 2'h0;
    @(posedge clk);
    #1 chk("flag_no_ctl", 36'h0, flg[2]);
    tc_ctl = 2'h3;
    cnt_zero = 2'h3;
    done_clr = 2'h3;
    @(posedge clk);
    #1 cnt_zero = 2'h0;
    done_clr = 2'h0;
    @(posedge clk);
    #1 chk("flag_dual", 36'h3, flg[2]);
    chk("flag_single", 36'h1, flg[0]);
    chk("done_to_cpu", 36'hC00, cpu[2] & 12'hC00);
    wr(32'hFFFF_FBFF);
    chk_gate(32'hFFFF_FBFF, 12'hFFF);
    done_clr = 2'h3;
    @(posedge clk);
    #1 done_clr = 2'h0;
    @(posedge clk);
    #1 chk("flag_cleared", 36'h0, flg[2]);
  endtask : test_flags

  // Verdict, the single exit of the run
  task automatic stop_test;
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    wr_en = 1'b0;
    wr_data = 32'h0000_0000;
    set_src(1'b1);
    cnt_zero = 2'h0;
    tc_ctl = 2'h0;
    done_clr = 2'h0;
    // Writes attempted under reset must not land
    repeat (10) @(posedge clk);
    #1 wr_en = 1'b1;
    wr_data = 32'hFFFF_FFFF;
    repeat (10) @(posedge clk);
    #1 wr_en = 1'b0;
    for (int l = 0; l < 3; l++)
      chk("reset_word", 36'h0, {rd[l], flg[l]});
    resetn = 1'b1;
    wr(32'hFFFF_FFFF);
    test_flags();
    // Flags set again so every source is live for the walk
    cnt_zero = 2'h3;
    @(posedge clk);
    #1 cnt_zero = 2'h0;
    // Walk one enable bit across the whole word
    for (int b = 0; b < 32; b++)
    begin
      wr(32'h0000_0001 << b);
      chk_gate(32'h0000_0001 << b, 12'hFFF);
    end
    // Everything enabled, nothing requesting
    set_src(1'b0);
    done_clr = 2'h3;
    wr(32'hFFFF_FFFF);
    done_clr = 2'h0;
    chk_gate(32'hFFFF_FFFF, 12'h000);
    // Back-to-back writes, last one wins
    wr(32'h1234_5678);
    wr(32'hA5A5_A5A5);
    chk_gate(32'hA5A5_A5A5, 12'h000);
    stop_test();
  end
endmodule : cpu_dma_interrupt_enable_reg_bench

`default_nettype wire
